// file: src/flash_host_ctrl.sv
// Host-side controller driving an asynchronous boot-sector flash by its pins.
// Software issues single bus cycles; command sequences are built in software.
// Contract
// - Commands are plain write cycles latching address and data.
// - Bypass mode programs one location in two writes, not four.
// - Host may suspend erase, use other sectors, then resume.
// - Host may place device in standby through control inputs.
// - Read: chip select and output gate low, write strobe high.
// - Write: write strobe and chip select low, output gate high.
`timescale 1ns/1ps
module flash_host_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Software command port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Flash pins
  output logic chipSel_n,
  output logic outGate_n,
  output logic wrStrobe_n,
  output logic devReset_n,
  output logic wordMode,
  output logic [flash_host_pkg::ADDR_W-1:0] flashAddr,
  output logic [flash_host_pkg::DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic topDataOrLowAddrOe,
  input wire logic [flash_host_pkg::DATA_W-1:0] dataIn,
  input wire logic operation_done_n
);
  localparam logic [7:0] ACC_C = 8'(flash_host_pkg::ACC_CYC);
  localparam logic [7:0] WR_C = 8'(flash_host_pkg::WR_CYC);
  localparam logic [7:0] REC_C = 8'(flash_host_pkg::RECOV_CYC);
  localparam logic [7:0] RST_C = 8'(flash_host_pkg::RST_CYC);

  flash_host_pkg::host_reg_t r, nxt;
  logic [flash_host_pkg::DATA_W-1:0] inSync1_r;
  logic [flash_host_pkg::DATA_W-1:0] inSync2_r;
  logic busy;

  // Pin data passes two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inSync1_r <= 16'h0000;
      inSync2_r <= 16'h0000;
    end else begin
      inSync1_r <= dataIn;
      inSync2_r <= inSync1_r;
    end
  end

  assign busy = (r.state != flash_host_pkg::IDLE);

  always_comb begin
    nxt = r;
    nxt.busRd = 16'h0000;
    nxt.doneSync = {r.doneSync[0], operation_done_n};
    nxt.doneSeen = r.doneSync[1];
    if (r.state != flash_host_pkg::IDLE) begin
      nxt.cnt = r.cnt - 8'h01;
    end
    case (r.state)
      flash_host_pkg::IDLE: begin
        nxt.pins.chipSel_n = r.standby;
        nxt.pins.outGate_n = 1'b1;
        nxt.pins.wrStrobe_n = 1'b1;
        nxt.pins.dataOe = 1'b0;
        if (regWr && regAddr == flash_host_pkg::REG_CTRL) begin
          nxt.standby = regWdata[flash_host_pkg::CTRL_STBY_BIT];
          // Deselect at once, not one cycle late
          nxt.pins.chipSel_n = regWdata[flash_host_pkg::CTRL_STBY_BIT];
          nxt.pins.wordMode = regWdata[flash_host_pkg::CTRL_WIDE_BIT];
          if (regWdata[3:0] == flash_host_pkg::OP_READ) begin
            nxt.state = flash_host_pkg::RD_WAIT;
            nxt.cnt = ACC_C;
            nxt.pins.chipSel_n = 1'b0;
            nxt.pins.outGate_n = 1'b0;
          end else if (regWdata[3:0] == flash_host_pkg::OP_WRITE) begin
            nxt.state = flash_host_pkg::WR_PULSE;
            nxt.cnt = WR_C;
            nxt.pins.chipSel_n = 1'b0;
            nxt.pins.wrStrobe_n = 1'b0;
            nxt.pins.dataOe = 1'b1;
          end else if (regWdata[3:0] == flash_host_pkg::OP_RESET) begin
            nxt.state = flash_host_pkg::RST_HOLD;
            nxt.cnt = RST_C;
            nxt.pins.devReset_n = 1'b0;
          end
        end else if (regWr && regAddr == flash_host_pkg::REG_ADDR) begin
          nxt.opAddr = regWdata[flash_host_pkg::ADDR_W:0];
        end else if (regWr && regAddr == flash_host_pkg::REG_WDATA) begin
          nxt.opData = regWdata[15:0];
        end
        // byte address: low bit to top data pin
        if (nxt.pins.wordMode) begin
          nxt.pins.addr = nxt.opAddr[flash_host_pkg::ADDR_W-1:0];
          nxt.pins.dataOut = nxt.opData;
        end else begin
          nxt.pins.addr = nxt.opAddr[flash_host_pkg::ADDR_W:1];
          nxt.pins.dataOut = {nxt.opAddr[0], 7'h00, nxt.opData[7:0]};
        end
      end
      flash_host_pkg::RD_WAIT: begin
        if (r.cnt == 8'h00) begin
          // byte mode keeps low lanes only
          nxt.rdData = r.pins.wordMode ? inSync2_r : {8'h00, inSync2_r[7:0]};
          nxt.pins.chipSel_n = r.standby;
          nxt.pins.outGate_n = 1'b1;
          nxt.state = flash_host_pkg::IDLE;
        end
      end
      flash_host_pkg::WR_PULSE: begin
        if (r.cnt == 8'h00) begin
          nxt.pins.wrStrobe_n = 1'b1;
          nxt.state = flash_host_pkg::WR_RECOV;
          nxt.cnt = REC_C;
        end
      end
      flash_host_pkg::WR_RECOV: begin
        if (r.cnt == 8'h00) begin
          nxt.pins.dataOe = 1'b0;
          nxt.pins.chipSel_n = r.standby;
          nxt.state = flash_host_pkg::IDLE;
        end
      end
      default: begin
        if (r.cnt == 8'h00) begin
          nxt.pins.devReset_n = 1'b1;
          nxt.state = flash_host_pkg::IDLE;
        end
      end
    endcase
    // Register read port, answer next cycle
    if (regRd) begin
      if (regAddr == flash_host_pkg::REG_CTRL) begin
        nxt.busRd = {9'h000, r.pins.devReset_n, r.standby, r.pins.wordMode, 4'h0};
      end else if (regAddr == flash_host_pkg::REG_ADDR) begin
        nxt.busRd = r.opAddr[15:0];
      end else if (regAddr == flash_host_pkg::REG_WDATA) begin
        nxt.busRd = r.opData;
      end else if (regAddr == flash_host_pkg::REG_STATUS) begin
        nxt.busRd = {14'h0000, ~r.doneSeen, busy};
      end else if (regAddr == flash_host_pkg::REG_RDATA) begin
        // polling and toggle bits read here by software
        nxt.busRd = r.rdData;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.state <= flash_host_pkg::IDLE;
      r.pins.chipSel_n <= 1'b1;
      r.pins.outGate_n <= 1'b1;
      r.pins.wrStrobe_n <= 1'b1;
      r.pins.devReset_n <= 1'b1;
      r.pins.wordMode <= 1'b1;
      r.doneSeen <= 1'b1;
      r.doneSync <= 2'b11;
    end else begin
      r <= nxt;
    end
  end

  assign regRdata = {16'h0000, r.busRd};
  assign chipSel_n = r.pins.chipSel_n;
  assign outGate_n = r.pins.outGate_n;
  assign wrStrobe_n = r.pins.wrStrobe_n;
  assign devReset_n = r.pins.devReset_n;
  assign wordMode = r.pins.wordMode;
  assign flashAddr = r.pins.addr;
  assign dataOut = r.pins.dataOut;
  assign dataOe = r.pins.dataOe;
  // Top pin carries low address bit in byte mode at all times, selected or not
  assign topDataOrLowAddrOe = r.pins.dataOe | ~r.pins.wordMode;

  // Counts low samples of the write strobe for the pulse length check
  logic [7:0] wrLowCnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrLowCnt_r <= 8'h00;
    end else if (!wrStrobe_n) begin
      wrLowCnt_r <= wrLowCnt_r + 8'h01;
    end else begin
      wrLowCnt_r <= 8'h00;
    end
  end

  chk_read_no_write: assert property (@(posedge clk) disable iff (rst)
    !outGate_n |-> wrStrobe_n && !chipSel_n) else $error("read with write strobe");
  chk_write_gate_high: assert property (@(posedge clk) disable iff (rst)
    !wrStrobe_n |-> outGate_n && !chipSel_n && dataOe) else $error("bad write cycle");
  chk_write_pulse_len: assert property (@(posedge clk) disable iff (rst)
    $rose(wrStrobe_n) |-> wrLowCnt_r == WR_C + 8'h01) else $error("write pulse length");
  chk_read_access_len: assert property (@(posedge clk) disable iff (rst)
    $fell(outGate_n) |-> ##[30:32] outGate_n) else $error("read access length");
  chk_reset_pulse: assert property (@(posedge clk) disable iff (rst)
    $fell(devReset_n) |-> ##[100:102] devReset_n) else $error("reset pulse length");
  // data stable while write strobe low
  chk_write_data_hold: assert property (@(posedge clk) disable iff (rst)
    !wrStrobe_n && $past(!wrStrobe_n) |-> $stable(dataOut) && $stable(flashAddr))
    else $error("write data moved");
  // standby keeps chip deselected when idle
  chk_standby_desel: assert property (@(posedge clk) disable iff (rst)
    r.standby && !busy && $past(!busy) |-> chipSel_n) else $error("standby selected");
  chk_byte_top_pin: assert property (@(posedge clk) disable iff (rst)
    !wordMode |-> topDataOrLowAddrOe) else $error("low address pin floating");
endmodule

// file: src/flash_host_pkg.sv
// Constants and carrier types for the boot-sector flash host controller.
// Assumes a 200 MHz system clock and an asynchronous flash on plain pins.
package flash_host_pkg;
  localparam int CLK_MHZ = 200;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int WORD_LOCS = 524288;
  localparam int BYTE_LOCS = 1048576;
  // Bus timing, in ns, and derived cycle counts (rounded up)
  localparam int ACC_NS = 150;
  localparam int WR_PULSE_NS = 50;
  localparam int ACC_CYC = (ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOV_CYC = 2;
  localparam int RST_PULSE_NS = 500;
  localparam int RST_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  // Register map of the controller's own command port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  // Control register fields
  localparam int CTRL_GO_LO = 0;
  localparam int CTRL_WIDE_BIT = 4;
  localparam int CTRL_STBY_BIT = 5;
  localparam int CTRL_RST_BIT = 6;
  // Operations started by writing the control register
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_WRITE = 4'h2;
  localparam logic [3:0] OP_RESET = 4'h3;

  typedef enum logic [2:0] {
    IDLE, RD_WAIT, WR_PULSE, WR_RECOV, RST_HOLD
  } host_state_t;

  typedef struct packed {
    logic chipSel_n;
    logic outGate_n;
    logic wrStrobe_n;
    logic devReset_n;
    logic wordMode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
  } pin_drive_t;

  typedef struct packed {
    host_state_t state;
    logic [7:0] cnt;
    pin_drive_t pins;
    logic standby;
    logic [ADDR_W:0] opAddr;
    logic [DATA_W-1:0] opData;
    logic [DATA_W-1:0] rdData;
    logic [DATA_W-1:0] busRd;
    logic doneSeen;
    logic [1:0] doneSync;
  } host_reg_t;
endpackage

// file: verif/flash_dev_model.sv
// Behavioural boot-sector flash seen from its pins.
// Assumes the host controller drives every control pin at all times.
`timescale 1ns/1ps
module flash_dev_model (
  // Control pins
  input wire logic chipSel_n,
  input wire logic outGate_n,
  input wire logic wrStrobe_n,
  input wire logic devReset_n,
  input wire logic wordMode,
  // Address, data and done pins
  input wire logic [18:0] flashAddr,
  input wire logic [15:0] dataOut,
  output logic [15:0] dataIn,
  output logic operation_done_n
);
  logic [15:0] mem [int];
  logic [15:0] idle;
  logic [15:0] rv;
  // bottom boot map: top main sector of 64 Kbyte is the protected one
  localparam logic [3:0] PROT_SECTOR = 4'hf;
  int key;
  realtime doneAt;
  initial begin
    idle = 16'h5a5a;
    doneAt = 0;
    operation_done_n = 1'b1;
  end
  always @* begin
    key = int'({wordMode, flashAddr, dataOut[15] & ~wordMode});
    rv = mem.exists(key) ? mem[key] : 16'hffff;
    if (!chipSel_n && !outGate_n && wrStrobe_n && devReset_n)
      dataIn = wordMode ? rv : {idle[15:8], rv[7:0]};
    else
      dataIn = idle;
  end
  // Released bus shows the inverse, not a stale value
  always @(posedge outGate_n) idle = ~dataIn;
  // latch on strobe rise, busy self timed
  always @(posedge wrStrobe_n) begin
    if (!chipSel_n && outGate_n && devReset_n && flashAddr[18:15] != PROT_SECTOR) begin
      mem[key] = wordMode ? dataOut : {8'h00, dataOut[7:0]};
      operation_done_n = 1'b0;
      doneAt = $realtime + 200;
    end
  end
  // completion or reset returns to array read
  always #5 if (!devReset_n || $realtime >= doneAt) operation_done_n = 1'b1;
  always @(negedge devReset_n) doneAt = 0;
endmodule

// file: verif/flash_host_ctrl_tb.sv
// Self-checking bench for the flash host controller.
// Assumes the pin-level flash model as the far side.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module flash_host_ctrl_tb;
  logic clk, rst, regWr, regRd;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, v;
  logic chipSel_n, outGate_n, wrStrobe_n, devReset_n, wordMode, dataOe, topOe, doneN;
  logic [18:0] flashAddr;
  logic [15:0] dataOut, dataIn;
  int mismatches = 0, checks_done = 0, cyc = 0;
  flash_host_ctrl DUT (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .chipSel_n(chipSel_n),
    .outGate_n(outGate_n), .wrStrobe_n(wrStrobe_n), .devReset_n(devReset_n),
    .wordMode(wordMode), .flashAddr(flashAddr), .dataOut(dataOut), .dataOe(dataOe),
    .topDataOrLowAddrOe(topOe), .dataIn(dataIn), .operation_done_n(doneN));
  flash_dev_model dev (.chipSel_n(chipSel_n), .outGate_n(outGate_n), .wrStrobe_n(wrStrobe_n),
    .devReset_n(devReset_n), .wordMode(wordMode), .flashAddr(flashAddr), .dataOut(dataOut),
    .dataIn(dataIn), .operation_done_n(doneN));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 0;
    #1 d = regRdata;
  endtask
  task automatic op(input logic [31:0] c);
    wr(flash_host_pkg::REG_CTRL, c);
    repeat (200) begin
      rd(flash_host_pkg::REG_STATUS, v);
      if (v[0] === 1'b0) break;
    end
  endtask
  task automatic finish_test;
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    rst = 1; regWr = 0; regRd = 0; regAddr = 0; regWdata = 0;
    repeat (20) @(posedge clk);
    rst <= 0;
    #1 `CHK("idle pins", 5'b11111, {chipSel_n, outGate_n, wrStrobe_n, devReset_n, wordMode})
    wr(flash_host_pkg::REG_ADDR, 32'h3);
    op(32'h11);
    rd(flash_host_pkg::REG_RDATA, v);
    `CHK("first read", 16'hffff, v[15:0])
    wr(flash_host_pkg::REG_ADDR, 32'h7_1234);
    wr(flash_host_pkg::REG_WDATA, 32'ha5c3);
    wr(flash_host_pkg::REG_CTRL, 32'h12);
    repeat (2) @(posedge clk);
    #1 `CHK("write pins", 4'b0101, {chipSel_n, outGate_n, wrStrobe_n, dataOe})
    `CHK("write addr", 19'h7_1234, flashAddr)
    `CHK("write data", 16'ha5c3, dataOut)
    repeat (200) begin
      rd(flash_host_pkg::REG_STATUS, v);
      if (v[0] === 1'b0) break;
    end
    `CHK("device busy", 2'b10, v[1:0])
    repeat (60) @(posedge clk);
    rd(flash_host_pkg::REG_STATUS, v);
    `CHK("device done", 2'b00, v[1:0])
    op(32'h11);
    rd(flash_host_pkg::REG_RDATA, v);
    `CHK("word readback", 16'ha5c3, v[15:0])
    wr(flash_host_pkg::REG_ADDR, 32'h5);
    wr(flash_host_pkg::REG_WDATA, 32'h3c);
    wr(flash_host_pkg::REG_CTRL, 32'h02);
    repeat (2) @(posedge clk);
    #1 `CHK("byte pins", 5'b01110, {wordMode, dataOut[15], topOe, flashAddr[1:0]})
    op(32'h01);
    op(32'h01);
    rd(flash_host_pkg::REG_RDATA, v);
    `CHK("byte readback", 16'h003c, v[15:0])
    wr(flash_host_pkg::REG_ADDR, 32'h4);
    op(32'h01);
    rd(flash_host_pkg::REG_RDATA, v);
    `CHK("byte sibling", 16'h00ff, v[15:0])
    op(32'h12);
    wr(flash_host_pkg::REG_CTRL, 32'h13);
    repeat (2) @(posedge clk);
    #1 `CHK("reset pin", 1'b0, devReset_n)
    op(32'h13);
    rd(flash_host_pkg::REG_STATUS, v);
    `CHK("abort done", 2'b00, v[1:0])
    rd(4'hf, v);
    `CHK("unmapped", 32'h0000_0000, v)
    wr(flash_host_pkg::REG_ADDR, 32'h7_8000);
    wr(flash_host_pkg::REG_WDATA, 32'h1234);
    op(32'h12);
    op(32'h11);
    rd(flash_host_pkg::REG_RDATA, v);
    `CHK("protected sector", 16'hffff, v[15:0])
    wr(flash_host_pkg::REG_CTRL, 32'h30);
    rd(flash_host_pkg::REG_CTRL, v);
    `CHK("ctrl readback", 32'h0000_0070, v)
    `CHK("standby pin", 1'b1, chipSel_n)
    finish_test;
  end
endmodule
